// ==== tsp_pkg.sv ====
// Constants of the timed serialising I/O port: register map, field
// positions, reset values and encodings. Assumes a 32-bit APB master.
// Contract
// R1 - Widths 1,4,8,16,32; one direction per port
// R2 - Drive pins or sample, optionally waiting
// R3 - Every port access finishes in one cycle
// R4 - Open drain: zero pulls low, one floats
// R5 - Open drain chosen per port, not pin
// R6 - Data passes serialiser and transfer register
// R7 - 16-bit counter times each transfer
// R8 - Counter readable; transfers deferrable to count
// R9 - Counter captured as timestamp per transfer
// R10 - Enabled link disables ports on shared pins
// R11 - Enabled narrower port beats wider port
// R12 - Unshared pins stay with the wider port
// R13 - Port always transfers its nominal width
// R14 - Six clock blocks, block 0 reference
// R15 - Clock block sourced, divided, from 1-bit port
// R16 - Input strobes honoured, output strobes generated
// R17 - After reset ports use clock block 0
// R18 - Pin events go to core as events
// R19 - Counter steps per port clock, wraps 65536
package tsp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_COND  = 8'h04;
   localparam logic [7:0] OFF_TIME  = 8'h08;
   localparam logic [7:0] OFF_DATA  = 8'h0C;
   localparam logic [7:0] OFF_COUNT = 8'h10;
   localparam logic [7:0] OFF_STAMP = 8'h14;
   localparam logic [7:0] OFF_STAT  = 8'h18;
   localparam logic [7:0] OFF_CLKDV = 8'h20; // Blocks 1..5 at +4 each
   // Control field positions
   localparam int CTL_EN     = 0;
   localparam int CTL_OUT    = 1;
   localparam int CTL_OD     = 2;
   localparam int CTL_CSEL   = 3;  // 3 bits
   localparam int CTL_COND   = 6;  // 2 bits
   localparam int CTL_TIMED  = 8;
   localparam int CTL_STRB   = 9;
   // Status field positions
   localparam int ST_RXV     = 0;
   localparam int ST_TXF     = 1;
   localparam int ST_LINK    = 2;
   localparam int ST_BUSY    = 3;
   // Clock divider register fields
   localparam int CKD_SRC    = 8;
   localparam int CKD_DIVW   = 8;
   // Counts and reset values
   localparam int NUM_CLKBLK = 6;
   localparam int WORD_W     = 32;
   localparam int CNT_W      = 16;
   localparam logic [9:0]  CTRL_RST  = 10'h000; // Clock block 0
   localparam logic [8:0]  CLKDV_RST = 9'h000;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   // Wait condition encodings
   typedef enum logic [1:0] {
      COND_NONE = 2'b00,
      COND_EQ   = 2'b01,
      COND_NE   = 2'b10
   } tsp_cond_e;
endpackage : tsp_pkg

// ==== tsp_sync.sv ====
// Two-flop synchroniser for pins entering the port clock domain.
// Assumes the inputs are asynchronous to clock.
`timescale 1ns/1ps
module tsp_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r  <= '0;
         syncOut <= '0;
      end else begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule : tsp_sync

// ==== tsp_clock_block.sv ====
// One clock block: a tick generator from the reference or a 1-bit pin.
// Assumes extSync is already synchronised to clock.
`timescale 1ns/1ps
module tsp_clock_block
   import tsp_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic [CKD_DIVW-1:0] divide,
   input  wire logic                useExt,
   input  wire logic                extSync,
   output logic                     tick
);
   logic                extPrev_r;
   logic [CKD_DIVW-1:0] div_r;
   logic                srcEdge;

   // Rising edge of the pin clock or every reference cycle
   assign srcEdge = useExt ? (extSync & ~extPrev_r) : 1'b1; // see R15

   // Divide the source; divide of zero passes every edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         extPrev_r <= 1'b0;
         div_r     <= '0;
      end else begin
         extPrev_r <= extSync;
         if (srcEdge) begin
            div_r <= (div_r >= divide) ? '0 : div_r + 1'b1; // see R15
         end
      end
   end

   assign tick = srcEdge && (div_r >= divide);
endmodule : tsp_clock_block

// ==== tsp_io_port.sv ====
// Timed serialising I/O port with six clock blocks and an APB slave.
// Assumes an APB master on clock, pins asynchronous, link and narrower
// port claims driven by neighbouring logic on clock.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module tsp_io_port
   import tsp_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut,
   output logic      [W-1:0] pinOe,
   input  wire logic         strobeIn,
   output logic              output_strobe,
   input  wire logic         extClockPin,
   input  wire logic         linkEnable,
   input  wire logic [W-1:0] narrowClaim,
   output logic              coreEvent
);
   localparam int BEATS = WORD_W / W;

   ////////////////////////////////////////////////////////////////////
   // Width check
   generate
      if (!(W == 1 || W == 4 || W == 8 || W == 16 || W == 32)) begin : g_bad
         $error("tsp_io_port: W must be 1, 4, 8, 16 or 32"); // see R1
      end
   endgenerate

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_SHIFT = 3'b100
   } tsp_state_e;

   // Register address decode shared by every register but the clock dividers
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : hit

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [9:0]          ctrl_r;
   logic [W-1:0]        cond_r;
   logic [CNT_W-1:0]    time_r;
   logic [WORD_W-1:0]   txWord_r;
   logic                txFull_r;
   logic [WORD_W-1:0]   rxWord_r;
   logic                rxValid_r;
   logic [CNT_W-1:0]    count_r;
   logic [CNT_W-1:0]    stamp_r;
   logic [8:0]          clkDiv_r [1:NUM_CLKBLK-1];
   logic [WORD_W-1:0]   shift_r;
   logic [5:0]          beat_r;
   tsp_state_e          state_r;
   tsp_state_e          state_nxt;
   logic [31:0]         prdata_r;
   logic                pslverr_r;
   logic [W-1:0]        pinOut_r;
   logic                strobe_r;
   logic                event_r;
   logic [W-1:0]        pinSync;
   logic                strobeSync;
   logic                extSync;
   logic [NUM_CLKBLK-1:0] ticks;
   logic                portTick;
   logic                wrAcc;
   logic                rdAcc;
   logic                mapped;
   logic                enable;
   logic                dirOut;
   logic                timeOk;
   logic                condOk;
   logic                strobeOk;
   logic                fire;
   logic                lastBeat;
   logic                done;
   logic [W-1:0]        usable;
   logic [WORD_W-1:0]   shiftIn;

   assign enable = ctrl_r[CTL_EN];
   assign dirOut = ctrl_r[CTL_OUT]; // Whole port one direction, see R1

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   tsp_sync #(.W(W)) u_pinSync (
      .clock   (clock),
      .rst_n   (rst_n),
      .asyncIn (pinIn),
      .syncOut (pinSync)
   );

   tsp_sync #(.W(2)) u_ctlSync (
      .clock   (clock),
      .rst_n   (rst_n),
      .asyncIn ({strobeIn, extClockPin}),
      .syncOut ({strobeSync, extSync})
   );

   ////////////////////////////////////////////////////////////////////
   // Clock blocks; block 0 ticks every reference cycle
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CLKBLK; gi++) begin : g_clk // see R14
         if (gi == 0) begin : g_ref
            tsp_clock_block u_blk (
               .clock   (clock),
               .rst_n   (rst_n),
               .divide  ('0),
               .useExt  (1'b0),
               .extSync (extSync),
               .tick    (ticks[gi])
            );
         end else begin : g_prog
            tsp_clock_block u_blk (
               .clock   (clock),
               .rst_n   (rst_n),
               .divide  (clkDiv_r[gi][CKD_DIVW-1:0]),
               .useExt  (clkDiv_r[gi][CKD_SRC]), // see R15
               .extSync (extSync),
               .tick    (ticks[gi])
            );
         end
      end
   endgenerate

   // Port clock select, block 0 after reset
   assign portTick = (ctrl_r[CTL_CSEL+:3] < 3'(NUM_CLKBLK))
                   ? ticks[ctrl_r[CTL_CSEL+:3]] : 1'b0; // see R17

   ////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states
   assign pready  = 1'b1; // see R3
   assign wrAcc   = psel & penable & pwrite;
   assign rdAcc   = psel & penable & ~pwrite;
   assign mapped  = (paddr[1:0] == 2'b00)
                  && (paddr <= OFF_STAT
                      || (paddr > OFF_CLKDV
                          && paddr < OFF_CLKDV + 8'(4 * NUM_CLKBLK)));
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // Read data is prepared in the setup cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_r <= ~mapped;
         prdata_r  <= '0;
         if (!pwrite) begin
            unique case (1'b1)
               hit(paddr, OFF_CTRL):  prdata_r <= 32'(ctrl_r);
               hit(paddr, OFF_COND):  prdata_r <= 32'(cond_r);
               hit(paddr, OFF_TIME):  prdata_r <= 32'(time_r);
               hit(paddr, OFF_DATA):  prdata_r <= rxWord_r;
               hit(paddr, OFF_COUNT): prdata_r <= 32'(count_r); // see R8
               hit(paddr, OFF_STAMP): prdata_r <= 32'(stamp_r); // see R9
               hit(paddr, OFF_STAT):  prdata_r <= 32'({state_r != ST_IDLE,
                                          linkEnable, txFull_r, rxValid_r});
               default: begin
                  if (mapped && paddr >= OFF_CLKDV + 8'h04) begin
                     prdata_r <= 32'(clkDiv_r[3'(paddr[4:2])]);
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         cond_r <= '0;
         time_r <= CNT_RST;
      end else begin
         if (wrAcc && hit(paddr, OFF_CTRL)) begin
            ctrl_r <= pwdata[9:0]; // Open drain per port, see R5
         end else if (fire && state_r == ST_ARMED) begin
            ctrl_r[CTL_TIMED] <= 1'b0; // Timed start is one-shot
         end
         if (wrAcc && hit(paddr, OFF_COND)) begin
            cond_r <= pwdata[W-1:0];
         end
         if (wrAcc && hit(paddr, OFF_TIME)) begin
            time_r <= pwdata[CNT_W-1:0]; // see R8
         end
      end
   end

   // Clock divider registers for blocks 1..5
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 1; i < NUM_CLKBLK; i++) begin
            clkDiv_r[i] <= CLKDV_RST;
         end
      end else if (wrAcc && mapped && paddr >= OFF_CLKDV + 8'h04) begin
         clkDiv_r[3'(paddr[4:2])] <= pwdata[8:0]; // see R14
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Port counter, one step per selected clock tick
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= CNT_RST;
      end else if (portTick) begin
         count_r <= count_r + 1'b1; // Wraps at 65536, see R7 see R19
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transfer gating terms
   assign timeOk   = !ctrl_r[CTL_TIMED] || (count_r == time_r); // see R8
   assign strobeOk = !ctrl_r[CTL_STRB] || strobeSync;            // see R16
   always_comb begin
      unique case (tsp_cond_e'(ctrl_r[CTL_COND+:2]))
         COND_EQ: condOk = (pinSync == cond_r); // see R2
         COND_NE: condOk = (pinSync != cond_r);
         default: condOk = 1'b1;
      endcase
   end

   // A beat moves W bits on a port tick once all gates agree
   always_comb begin
      fire = 1'b0;
      if (portTick && enable && !linkEnable && strobeOk) begin
         if (state_r == ST_ARMED) begin
            fire = timeOk && (dirOut || condOk);
         end else if (state_r == ST_SHIFT) begin
            fire = 1'b1;
         end
      end
   end

   assign lastBeat = (beat_r == 6'(BEATS - 1));
   assign done     = fire && lastBeat;
   // Full nominal width regardless of pins lost to others
   assign shiftIn  = {pinSync, shift_r[WORD_W-1:W]}; // see R13

   ////////////////////////////////////////////////////////////////////
   // Sequencer state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (enable && (!dirOut || txFull_r)) begin
               state_nxt = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (done) begin
               state_nxt = ST_IDLE;
            end else if (fire) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (!enable || (wrAcc && hit(paddr, OFF_CTRL)
                      && pwdata[CTL_OUT] != dirOut)) begin // see R6
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Serialiser, beat count and timestamp
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shift_r  <= '0;
         beat_r   <= '0;
         stamp_r  <= CNT_RST;
         pinOut_r <= '1;
      end else begin
         if (state_r == ST_IDLE && dirOut && txFull_r) begin
            shift_r <= txWord_r; // Transfer register to serialiser, see R6
            beat_r  <= '0;
         end else if (state_r == ST_IDLE) begin
            beat_r  <= '0;
         end else if (fire) begin
            beat_r <= lastBeat ? '0 : beat_r + 1'b1;
            if (dirOut) begin
               pinOut_r <= shift_r[W-1:0];                  // see R2
               shift_r  <= WORD_W'(shift_r >> W);
            end else begin
               shift_r  <= shiftIn;                         // see R6
            end
            if (state_r == ST_ARMED) begin
               stamp_r <= count_r; // First beat marks the transfer, see R9
            end
         end
      end
   end

   // Transfer register, host side; hardware set wins over read clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txWord_r  <= '0;
         txFull_r  <= 1'b0;
         rxWord_r  <= '0;
         rxValid_r <= 1'b0;
      end else begin
         if (wrAcc && hit(paddr, OFF_DATA) && !txFull_r) begin
            txWord_r <= pwdata;
            txFull_r <= 1'b1;
         end else if (state_r == ST_IDLE && dirOut && txFull_r) begin
            txFull_r <= 1'b0; // Moved into the serialiser
         end
         if (done && !dirOut) begin
            rxWord_r  <= shiftIn;
            rxValid_r <= 1'b1;
         end else if (rdAcc && hit(paddr, OFF_DATA)) begin
            rxValid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output strobe and core event
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strobe_r <= 1'b0;
         event_r  <= 1'b0;
      end else begin
         if (portTick || !enable) begin
            strobe_r <= fire && dirOut; // Held to the next tick, see R16
         end
         // Input word landed or output word drained wakes the core
         event_r <= done; // see R18
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin ownership and drive
   // A link takes every pin, an enabled narrower port its claimed pins; without a link the rest stay ours
   assign usable = linkEnable ? '0 : ~narrowClaim; // see R10 see R11 see R12

   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (ctrl_r[CTL_OD]) begin
            pinOut[i] = 1'b0;                                // see R4
            pinOe[i]  = enable && dirOut && usable[i] && !pinOut_r[i];
         end else begin
            pinOut[i] = pinOut_r[i];
            pinOe[i]  = enable && dirOut && usable[i];
         end
      end
   end

   assign output_strobe = strobe_r;
   assign coreEvent     = event_r;
endmodule : tsp_io_port

// ==== tsp_io_port_props.sv ====
// Checker for the I/O port: bus answers, pin ownership, word timing.
// Assumes it is bound to tsp_io_port and sees only that module's ports.
`timescale 1ns/1ps
module tsp_io_port_props
   import tsp_pkg::*;
#(
   parameter int W = 4
) (
   input wire logic         clock,
   input wire logic         rst_n,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic [7:0]   paddr,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic [W-1:0] pinOe,
   input wire logic         linkEnable,
   input wire logic [W-1:0] narrowClaim,
   input wire logic         output_strobe,
   input wire logic         coreEvent
);
   // Beats after the first one; only true while the port clock ticks every reference cycle
   localparam int LAST = 32 / W - 1;

   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////
   // Bus answers: no wait states, unmapped offsets refused
   a_ready_always: assert property (pready)
      else $error("pready dropped");
   a_bad_addr: assert property (
      psel && !penable && paddr == 8'h40 |=> pslverr && pready)
      else $error("unmapped access not refused");
   a_good_addr: assert property (
      psel && !penable && paddr == OFF_COUNT |=> !pslverr)
      else $error("counter read refused");

   ////////////////////////////////////////////////////////////////////
   // Pin ownership: link and narrower ports win the pins
   a_link_no_drive: assert property (linkEnable |-> pinOe == '0)
      else $error("pin driven under link");
   a_link_halts: assert property (
      linkEnable && $past(linkEnable) |-> !$rose(output_strobe))
      else $error("beat started under link");
   a_narrow_wins: assert property ((pinOe & narrowClaim) == '0)
      else $error("pin driven under narrower port");

   ////////////////////////////////////////////////////////////////////
   // Word framing and event delivery
   a_event_pulse: assert property (coreEvent |=> !coreEvent)
      else $error("event longer than one cycle");
   a_word_ends: assert property (
      $rose(output_strobe) |-> ##[LAST:LAST] coreEvent)
      else $error("word not ended after its beats");

   c_bad_addr: cover property (psel && !penable && paddr == 8'h40);
   c_word_out: cover property ($rose(output_strobe));
   c_narrow: cover property (narrowClaim != '0 && pinOe != '0);
endmodule : tsp_io_port_props

// ==== tsp_pin_model.sv ====
// Application hardware on the port pins: strobed source and sink.
// Assumes pulled-up pins and a bench that calls its tasks.
`timescale 1ns/1ps
module tsp_pin_model #(
   parameter int W = 4
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] pinOut,
   input  wire logic [W-1:0] pinOe,
   input  wire logic         output_strobe,
   output logic      [W-1:0] pinIn,
   output logic              strobeIn,
   output logic              extClockPin
);
   logic [W-1:0] lvl;
   logic [31:0]  rxWord = 32'h0000_0000;
   int           rxBeats = 0;

   // Board pull-up: an undriven pin reads high
   assign lvl = (pinOe & pinOut) | ~pinOe;

   // One beat each strobed cycle, lowest bits arrive first
   always @(posedge clock) begin
      if (output_strobe === 1'b1) begin
         rxWord <= {lvl, rxWord[31:W]};
         rxBeats <= rxBeats + 1;
      end
   end

   // Quiet pins and a stopped clock outside transfers
   initial begin
      pinIn = '0;
      strobeIn = 1'b0;
      extClockPin = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // One strobed beat; data inverted after so stale values never pass
   task automatic send_nib(input logic [W-1:0] n);
      @(posedge clock);
      pinIn <= n;
      strobeIn <= 1'b1;
      @(posedge clock);
      pinIn <= ~n;
      strobeIn <= 1'b0;
   endtask : send_nib

   // Slow clock so the synchroniser sees every edge
   task automatic ext_edges(input int n);
      repeat (n) begin
         repeat (3) @(posedge clock);
         extClockPin <= 1'b1;
         repeat (3) @(posedge clock);
         extClockPin <= 1'b0;
      end
   endtask : ext_edges
endmodule : tsp_pin_model

// ==== tsp_io_port_tb.sv ====
// Self-checking bench for the timed I/O port, driven over APB.
// Assumes the pin model on the pins and the checker bound below.
`timescale 1ns/1ps
module tsp_io_port_tb
   import tsp_pkg::*;
;
   localparam int W = 4;
   localparam logic [31:0] IN_WORD = 32'h1234_567A;
   logic         clock = 1'b0;
   logic         rst_n = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0000_0000;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic [W-1:0] pinIn;
   logic [W-1:0] pinOut;
   logic [W-1:0] pinOe;
   logic         strobeIn;
   logic         output_strobe;
   logic         extClockPin;
   logic         linkEnable = 1'b0;
   logic [W-1:0] narrowClaim = '0;
   logic         coreEvent;
   logic [31:0]  rdData;
   logic         rdErr;
   logic [31:0]  cnt0;
   logic         odMode = 1'b0;
   logic         odHigh = 1'b0;
   int           miscompares = 0;
   int           compares = 0;
   int           beats0;

   always #25 clock = ~clock;

   tsp_io_port #(.W(W)) dut_u (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .strobeIn(strobeIn), .output_strobe(output_strobe),
      .extClockPin(extClockPin), .linkEnable(linkEnable),
      .narrowClaim(narrowClaim), .coreEvent(coreEvent));

   tsp_pin_model #(.W(W)) pm_u (
      .clock(clock), .pinOut(pinOut), .pinOe(pinOe),
      .output_strobe(output_strobe), .pinIn(pinIn), .strobeIn(strobeIn),
      .extClockPin(extClockPin));

   // Open drain must never drive a pin high
   always @(posedge clock) begin
      if (odMode && (pinOe & pinOut) != '0) begin
         odHigh <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Only the watchdog ends a hung access phase
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Bounded wait for the word-done event
   task automatic wait_evt();
      int n;
      n = 0;
      while (coreEvent !== 1'b1 && n < 500) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(32'(n < 500), 32'h0000_0001);
   endtask : wait_evt

   task automatic send_out(input logic [31:0] word);
      beats0 = pm_u.rxBeats;
      apb(1'b1, OFF_DATA, word);
      wait_evt();
      repeat (2) @(posedge clock);
      chk(pm_u.rxWord, word);
      chk(32'(pm_u.rxBeats - beats0), 32'h0000_0008);
   endtask : send_out

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b0, OFF_CTRL, '0);
      chk(rdData, 32'h0000_0000);
      apb(1'b0, 8'h40, '0);
      chk(32'(rdErr), 32'h0000_0001);
      apb(1'b1, 8'h02, 32'h0000_0001);
      chk(32'(rdErr), 32'h0000_0001);
      for (int i = 1; i <= 5; i++) begin
         apb(1'b1, OFF_CLKDV + 8'(4 * i), 32'(3 * i));
         apb(1'b0, OFF_CLKDV + 8'(4 * i), '0);
         chk(rdData, 32'(3 * i));
      end
      $display("test registers done");
      // Counter steps each reference tick, then each second pin edge
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      apb(1'b0, OFF_COUNT, '0);
      cnt0 = rdData;
      apb(1'b0, OFF_COUNT, '0);
      chk({16'h0, rdData[15:0] - cnt0[15:0]}, 32'h0000_0003);
      apb(1'b1, OFF_CLKDV + 8'h04, 32'h0000_0101);
      apb(1'b1, OFF_CTRL, 32'h0000_0009);
      apb(1'b0, OFF_COUNT, '0);
      cnt0 = rdData;
      pm_u.ext_edges(8);
      apb(1'b0, OFF_COUNT, '0);
      chk({16'h0, rdData[15:0] - cnt0[15:0]}, 32'h0000_0004);
      $display("test counter done");
      // Timed output word; stamp must equal the chosen count
      apb(1'b1, OFF_CTRL, 32'h0000_0003);
      apb(1'b0, OFF_COUNT, '0);
      cnt0 = {16'h0, rdData[15:0] + 16'h0028};
      apb(1'b1, OFF_TIME, cnt0);
      apb(1'b1, OFF_CTRL, 32'h0000_0103);
      send_out(32'h8765_4321);
      apb(1'b0, OFF_STAMP, '0);
      chk(rdData, cnt0);
      narrowClaim <= 4'b0011;
      repeat (2) @(posedge clock);
      chk(32'(pinOe), 32'h0000_000C);
      narrowClaim <= '0;
      linkEnable <= 1'b1;
      beats0 = pm_u.rxBeats;
      apb(1'b1, OFF_DATA, 32'h0000_00F0);
      repeat (20) @(posedge clock);
      chk(32'(pinOe), 32'h0000_0000);
      chk(32'(pm_u.rxBeats - beats0), 32'h0000_0000);
      apb(1'b0, OFF_STAT, '0);
      chk(32'(rdData[ST_LINK]), 32'h0000_0001);
      linkEnable <= 1'b0;
      wait_evt();
      $display("test output done");
      // Open drain: ones float and read high through the pull-up
      apb(1'b1, OFF_CTRL, 32'h0000_0007);
      odMode <= 1'b1;
      send_out(32'h0F0F_A55A);
      odMode <= 1'b0;
      chk(32'(odHigh), 32'h0000_0000);
      $display("test open drain done");
      // Strobed input waiting on a pin match; first beat refused
      apb(1'b1, OFF_CTRL, 32'h0000_0241);
      apb(1'b1, OFF_COND, 32'h0000_000A);
      pm_u.send_nib(4'h5);
      for (int k = 0; k < 8; k++) begin
         pm_u.send_nib(IN_WORD[4 * k +: 4]);
      end
      wait_evt();
      apb(1'b0, OFF_STAT, '0);
      chk(32'(rdData[ST_RXV]), 32'h0000_0001);
      apb(1'b0, OFF_DATA, '0);
      chk(rdData, IN_WORD);
      apb(1'b0, OFF_STAT, '0);
      chk(32'(rdData[ST_RXV]), 32'h0000_0000);
      $display("test input done");
      close_out();
   end

   // Watchdog: 20000 cycles, far beyond the tests
   initial begin
      #1_000_000;
      miscompares++;
      close_out();
   end
endmodule : tsp_io_port_tb

bind tsp_io_port tsp_io_port_props #(.W(W)) props_u (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .pinOe(pinOe),
   .linkEnable(linkEnable), .narrowClaim(narrowClaim),
   .output_strobe(output_strobe), .coreEvent(coreEvent));
